//--- src/rgl_pkg.sv
// constants and types for the rgb gamma curve block
package rgl_pkg;
   typedef logic [7:0]  rgl_level_t;
   typedef logic [15:0] rgl_addr_t;

   // register window of the three curve tables
   localparam rgl_addr_t RGL_RED_FIRST   = 16'h0150;
   localparam rgl_addr_t RGL_RED_LAST    = 16'h016F;
   localparam rgl_addr_t RGL_GREEN_FIRST = 16'h0170;
   localparam rgl_addr_t RGL_GREEN_LAST  = 16'h018F;
   localparam rgl_addr_t RGL_BLUE_FIRST  = 16'h0190;
   localparam rgl_addr_t RGL_BLUE_LAST   = 16'h01AF;

   localparam int RGL_POINTS    = 32;
   localparam int RGL_CHANNELS  = 3;
   localparam int RGL_ENTRIES   = RGL_POINTS * RGL_CHANNELS;
   localparam int RGL_STEP      = 8;
   localparam int RGL_LAST_SPAN = 7;
   localparam int RGL_LATENCY   = 1;
   localparam rgl_level_t RGL_FULL_SCALE = 8'hFF;
   localparam rgl_level_t RGL_ZERO       = 8'h00;

   // reset level of point n (0-based): 8*(n+1), last point full scale
   function automatic rgl_level_t rgl_reset_point(input int n);
      if (n >= RGL_POINTS - 1) begin
         return RGL_FULL_SCALE;
      end
      return 8'((n + 1) * RGL_STEP);
   endfunction

   // true when the address falls in one of the curve tables
   function automatic logic rgl_in_table(input rgl_addr_t a);
      return (a >= RGL_RED_FIRST) && (a <= RGL_BLUE_LAST);
   endfunction

   // entry index 0..95 of a table address
   function automatic logic [6:0] rgl_entry(input rgl_addr_t a);
      rgl_addr_t d;
      d = a - RGL_RED_FIRST;
      return d[6:0];
   endfunction
endpackage

//--- src/rgl_interp.sv
// one channel's curve lookup with linear interpolation
`timescale 1ns/100ps
module rgl_interp
   import rgl_pkg::*;
(
   // curve points, point n at bits 8n+7:8n
   input  wire logic [rgl_pkg::RGL_POINTS*8-1:0] curve,
   // level in and corrected level out
   input  wire rgl_pkg::rgl_level_t              level_in,
   output rgl_pkg::rgl_level_t                   level_out
);
   import rgl_pkg::*;

   always_comb begin
      int         seg;
      int         frac;
      int         lo;
      int         hi;
      int         prod;
      int         step;
      seg  = int'(level_in[7:3]);
      frac = int'(level_in[2:0]);
      step = 0;
      hi   = int'(curve[seg*8 +: 8]);
      // below the first point the curve starts from zero
      lo   = int'(RGL_ZERO);
      if (seg > 0) begin
         lo = int'(curve[(seg-1)*8 +: 8]);
      end
      prod = (hi - lo) * frac;
      // last segment runs 248..255, seven steps wide
      if (seg == RGL_POINTS - 1) begin
         step = prod / RGL_LAST_SPAN;
      end else begin
         step = prod / RGL_STEP;
      end
      level_out = 8'(lo + step);
   end
endmodule

//--- src/rgl_top.sv
// rgb gamma curve tables with per-pixel interpolated correction
`timescale 1ns/100ps
module rgl_top
   import rgl_pkg::*;
(
   // clock and reset
   input  wire logic                clk,
   input  wire logic                rst_b,
   // register port
   input  wire rgl_pkg::rgl_addr_t  reg_addr,
   input  wire logic                reg_wr,
   input  wire rgl_pkg::rgl_level_t reg_wdata,
   input  wire logic                reg_rd,
   output rgl_pkg::rgl_level_t      reg_rdata,
   output logic                     reg_rvalid,
   // pixels from upstream
   input  wire logic                pix_valid,
   input  wire rgl_pkg::rgl_level_t pix_red,
   input  wire rgl_pkg::rgl_level_t pix_green,
   input  wire rgl_pkg::rgl_level_t pix_blue,
   // corrected pixels downstream
   output logic                     out_valid,
   output rgl_pkg::rgl_level_t      out_red,
   output rgl_pkg::rgl_level_t      out_green,
   output rgl_pkg::rgl_level_t      out_blue
);
   import rgl_pkg::*;

   // red 0..31, green 32..63, blue 64..95
   rgl_level_t                        curve_table [0:RGL_ENTRIES-1];
   rgl_level_t                        next_curve_table [0:RGL_ENTRIES-1];
   rgl_level_t                        next_reg_rdata;
   logic                              next_reg_rvalid;
   logic       [RGL_POINTS*8-1:0]     curve_flat [0:RGL_CHANNELS-1];
   rgl_level_t                        chan_in    [0:RGL_CHANNELS-1];
   rgl_level_t                        chan_out   [0:RGL_CHANNELS-1];
   logic                              next_out_valid;
   rgl_level_t                        next_out_red;
   rgl_level_t                        next_out_green;
   rgl_level_t                        next_out_blue;

   // table writes
   always_comb begin
      for (int i = 0; i < RGL_ENTRIES; i++) begin
         next_curve_table[i] = curve_table[i];
      end
      if (reg_wr && rgl_in_table(reg_addr)) begin
         next_curve_table[rgl_entry(reg_addr)] = reg_wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < RGL_ENTRIES; i++) begin
            curve_table[i] <= rgl_reset_point(i % RGL_POINTS);
         end
      end else begin
         for (int i = 0; i < RGL_ENTRIES; i++) begin
            curve_table[i] <= next_curve_table[i];
         end
      end
   end

   // register reads, answered one cycle later; unmapped reads zero
   // read data hold until the next read answer
   always_comb begin
      next_reg_rvalid = reg_rd;
      next_reg_rdata  = reg_rdata;
      if (reg_rd) begin
         next_reg_rdata = RGL_ZERO;
         if (rgl_in_table(reg_addr)) begin
            next_reg_rdata = curve_table[rgl_entry(reg_addr)];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rvalid <= 1'b0;
         reg_rdata  <= RGL_ZERO;
      end else begin
         reg_rvalid <= next_reg_rvalid;
         reg_rdata  <= next_reg_rdata;
      end
   end

   assign chan_in[0] = pix_red;
   assign chan_in[1] = pix_green;
   assign chan_in[2] = pix_blue;

   // one interpolator per channel
   genvar c;
   genvar p;
   generate
      for (c = 0; c < RGL_CHANNELS; c++) begin : g_chan
         for (p = 0; p < RGL_POINTS; p++) begin : g_point
            assign curve_flat[c][p*8 +: 8] = curve_table[c*RGL_POINTS + p];
         end
         rgl_interp u_interp (
            .curve     (curve_flat[c]),
            .level_in  (chan_in[c]),
            .level_out (chan_out[c])
         );
      end
   endgenerate

   // output stage; data hold while no pixel arrives
   always_comb begin
      next_out_valid = pix_valid;
      next_out_red   = out_red;
      next_out_green = out_green;
      next_out_blue  = out_blue;
      if (pix_valid) begin
         next_out_red   = chan_out[0];
         next_out_green = chan_out[1];
         next_out_blue  = chan_out[2];
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         out_valid <= 1'b0;
         out_red   <= RGL_ZERO;
         out_green <= RGL_ZERO;
         out_blue  <= RGL_ZERO;
      end else begin
         out_valid <= next_out_valid;
         out_red   <= next_out_red;
         out_green <= next_out_green;
         out_blue  <= next_out_blue;
      end
   end
endmodule

//--- tb/rgl_asserts.sv
// port checks for the gamma curve block
`timescale 1ns/100ps
module rgl_asserts
   import rgl_pkg::*;
(
   // watched ports
   input wire logic                clk,
   input wire logic                rst_b,
   input wire rgl_pkg::rgl_addr_t  reg_addr,
   input wire logic                reg_rd,
   input wire rgl_pkg::rgl_level_t reg_rdata,
   input wire logic                reg_rvalid,
   input wire logic                pix_valid,
   input wire rgl_pkg::rgl_level_t pix_red,
   input wire logic                out_valid,
   input wire rgl_pkg::rgl_level_t out_red
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   rd_answer_a: assert property (reg_rd |=> reg_rvalid) else $error("no read answer");
   rd_only_a: assert property (!reg_rd |=> !reg_rvalid) else $error("stray answer");
   rd_hold_a: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("rdata moved");
   unmapped_a: assert property (reg_rd && (reg_addr < 16'h0150 || reg_addr > 16'h01AF)
      |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
   pix_lat_a: assert property (pix_valid |=> out_valid) else $error("pixel lost");
   no_spur_a: assert property (!pix_valid |=> !out_valid) else $error("stray pixel");
   out_hold_a: assert property (!pix_valid |=> $stable(out_red)) else $error("out moved");
   zero_in_a: assert property (pix_valid && pix_red == 8'h00 |=> out_red == 8'h00)
      else $error("zero input not zero");
endmodule
bind rgl_top rgl_asserts chk (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .pix_valid(pix_valid), .pix_red(pix_red),
   .out_valid(out_valid), .out_red(out_red));

//--- tb/rgl_src.sv
// upstream pixel source model
`timescale 1ns/100ps
module rgl_src
   import rgl_pkg::*;
(
   // pixel stream
   input  wire logic           clk,
   output logic                pix_valid,
   output rgl_pkg::rgl_level_t pix_red,
   output rgl_pkg::rgl_level_t pix_green,
   output rgl_pkg::rgl_level_t pix_blue
);
   initial begin
      pix_valid = 1'b0;
      {pix_red, pix_green, pix_blue} = 24'h000000;
   end
   task automatic send(input rgl_level_t r, input rgl_level_t g, input rgl_level_t b);
      @(negedge clk);
      pix_valid = 1'b1;
      {pix_red, pix_green, pix_blue} = {r, g, b};
      @(negedge clk);
      pix_valid = 1'b0;
      // stale data inverted so it is never mistaken for a pixel
      {pix_red, pix_green, pix_blue} = ~{r, g, b};
   endtask
endmodule

//--- tb/tb.sv
// self-checking bench for the gamma curve block
`timescale 1ns/100ps
module tb;
   import rgl_pkg::*;
   logic       clk = 1'b0;
   logic       rst_b = 1'b0;
   rgl_addr_t  reg_addr = 16'h0000;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   rgl_level_t reg_wdata = 8'h00;
   rgl_level_t reg_rdata, pix_red, pix_green, pix_blue, out_red, out_green, out_blue;
   logic       reg_rvalid, pix_valid, out_valid;
   int         err_count = 0;
   int         num_checks = 0;
   always #12.5 clk = ~clk;
   rgl_top dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .pix_valid(pix_valid), .pix_red(pix_red), .pix_green(pix_green), .pix_blue(pix_blue),
      .out_valid(out_valid), .out_red(out_red), .out_green(out_green), .out_blue(out_blue));
   rgl_src src (.clk(clk), .pix_valid(pix_valid), .pix_red(pix_red), .pix_green(pix_green),
      .pix_blue(pix_blue));
   task automatic chk(input string what, input rgl_level_t exp, input rgl_level_t got);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input rgl_addr_t a, input rgl_level_t d);
      @(negedge clk);
      {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
      @(negedge clk);
      reg_wr = 1'b0;
   endtask
   task automatic rd(input rgl_addr_t a, input rgl_level_t exp);
      @(negedge clk);
      {reg_addr, reg_rd} = {a, 1'b1};
      @(negedge clk);
      reg_rd = 1'b0;
      chk("reg_rvalid", 8'h01, 8'(reg_rvalid));
      chk("reg_rdata", exp, reg_rdata);
   endtask
   task automatic pix(input rgl_level_t r, g, b, er, eg, eb);
      src.send(r, g, b);
      chk("out_valid", 8'h01, 8'(out_valid));
      chk("out_red", er, out_red);
      chk("out_green", eg, out_green);
      chk("out_blue", eb, out_blue);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      #20us;
      err_count++;
      conclude();
   end
   initial begin
      repeat (20) @(negedge clk);
      rst_b = 1'b1;
      for (int n = 0; n < 96; n++) begin
         rd(16'h0150 + 16'(n), (n % 32 == 31) ? 8'hFF : 8'(8 * (n % 32 + 1)));
      end
      wr(16'h01B0, 8'h55);
      rd(16'h01B0, 8'h00);
      rd(16'h014F, 8'h00);
      pix(8'h00, 8'hFF, 8'h64, 8'h00, 8'hFF, 8'h64);
      wr(16'h015C, 8'h00);
      wr(16'h0170, 8'h40);
      wr(16'h01AF, 8'h00);
      rd(16'h015C, 8'h00);
      rd(16'h0170, 8'h40);
      rd(16'h01AF, 8'h00);
      // falling segments and the short last segment
      pix(8'h64, 8'h04, 8'hFC, 8'h30, 8'h20, 8'h6B);
      conclude();
   end
endmodule
